/* File: rtl/ocm_pkg.sv */
// constants and helpers for the compare output mode logic of two 16-bit timers
// assumes a byte-wide data-space register port and one 25 MHz clock
package ocm_pkg;

  // ***************************************************************
  // address map
  // ***************************************************************
  // i/o-space offsets move up by this much in data space
  localparam logic [7:0] IO_DATA_OFFSET   = 8'h20;
  localparam logic [7:0] T1_CTRL_A_IO     = 8'h2f;  // timer one control a, i/o offset
  localparam logic [7:0] T1_CTRL_B_IO     = 8'h2e;  // timer one control b, i/o offset
  localparam logic [7:0] T3_CTRL_A_EXT    = 8'h8b;  // timer three control a, extended space
  localparam logic [7:0] T3_CTRL_B_EXT    = 8'h8a;  // timer three control b, extended space

  // ***************************************************************
  // field layout and reset values
  // ***************************************************************
  localparam int         CHAN_A_LSB       = 6;      // channel a output mode, bits 7:6
  localparam int         CHAN_B_LSB       = 4;      // channel b output mode, bits 5:4
  localparam int         CHAN_C_LSB       = 2;      // channel c output mode, bits 3:2
  localparam int         WAVE_LOW_LSB     = 0;      // low waveform bits in control a
  localparam int         WAVE_HIGH_LSB    = 3;      // high waveform bits in control b
  localparam logic [7:0] CTRL_RESET       = 8'h00;
  localparam logic [7:0] CTRL_B_WMASK     = 8'hdf;  // bit 5 of control b is not stored
  localparam logic [7:0] READ_IDLE        = 8'h00;  // unmapped reads give zero

  // ***************************************************************
  // output mode codes and special waveform modes
  // ***************************************************************
  localparam logic [1:0] OUT_OFF          = 2'h0;
  localparam logic [1:0] OUT_TOGGLE       = 2'h1;
  localparam logic [1:0] OUT_CLEAR        = 2'h2;
  localparam logic [1:0] OUT_SET          = 2'h3;
  localparam logic [3:0] WAVE_FAST_A_TOP  = 4'hf;
  localparam logic [3:0] WAVE_PFC_A_TOP   = 4'h9;
  localparam logic [3:0] WAVE_PC_A_TOP    = 4'hb;

  // kind of counting sequence a waveform mode selects
  typedef enum logic [1:0] {
    CLS_NON_PWM  = 2'b00,
    CLS_FAST     = 2'b01,
    CLS_DUAL     = 2'b10,
    CLS_RESERVED = 2'b11
  } wave_class_t;

  // map the 4-bit waveform mode onto its class
  function automatic wave_class_t wave_class(input logic [3:0] wave);
    case (wave)
      4'h0, 4'h4, 4'hc:               wave_class = CLS_NON_PWM;
      4'h5, 4'h6, 4'h7, 4'he, 4'hf:   wave_class = CLS_FAST;
      4'hd:                           wave_class = CLS_RESERVED;
      default:                        wave_class = CLS_DUAL;
    endcase
  endfunction

endpackage

/* File: rtl/channel_output_unit.sv */
// next-state logic for one compare output channel
// assumes match, bottom and direction are already qualified by the timer tick
`timescale 1ns/1ns
`default_nettype none

module channel_output_unit #(
  parameter bit IS_CHAN_A = 1'b0        // only channel a may toggle in pwm modes
) (
  input  wire logic [1:0] out_mode,     // channel output mode field
  input  wire logic [3:0] wave_mode,    // full waveform mode field
  input  wire logic       match,        // compare match this cycle
  input  wire logic       bottom,       // counter at bottom this cycle
  input  wire logic       count_down,   // dual-slope direction
  input  wire logic       cmp_at_top,   // compare value equals top
  input  wire logic       state_now,    // present output state
  output logic            connected,    // output owns the pin
  output logic            state_next    // output state after this cycle
);

  // ***************************************************************
  // action decode
  // ***************************************************************
  // one table per counting class; state only moves while connected
  always_comb begin
    connected  = 1'b0;
    state_next = state_now;
    case (ocm_pkg::wave_class(wave_mode))
      ocm_pkg::CLS_NON_PWM: begin
        // RULE4: zero disconnects
        connected = (out_mode != ocm_pkg::OUT_OFF);
        // RULE5: toggle, clear, set
        if (match) begin
          case (out_mode)
            ocm_pkg::OUT_TOGGLE: state_next = ~state_now;
            ocm_pkg::OUT_CLEAR:  state_next = 1'b0;
            ocm_pkg::OUT_SET:    state_next = 1'b1;
            default:             state_next = state_now;
          endcase
        end
      end
      ocm_pkg::CLS_FAST: begin
        if (out_mode == ocm_pkg::OUT_TOGGLE) begin
          // RULE6: channel a, mode 15 only
          connected = IS_CHAN_A && (wave_mode == ocm_pkg::WAVE_FAST_A_TOP);
          if (connected && match) begin
            state_next = ~state_now;
          end
        end else if (out_mode[1]) begin
          connected = 1'b1;
          // RULE9: match at top ignored
          if (match && !cmp_at_top) begin
            // RULE7: non-inverting clears on match
            // RULE8: inverting sets on match
            state_next = (out_mode == ocm_pkg::OUT_SET);
          end
          // bottom comes after the match in a period, so it wins
          if (bottom) begin
            state_next = (out_mode == ocm_pkg::OUT_CLEAR);
          end
        end
      end
      ocm_pkg::CLS_DUAL: begin
        if (out_mode == ocm_pkg::OUT_TOGGLE) begin
          // RULE10: channel a, mode 9 or 11
          connected = IS_CHAN_A && ((wave_mode == ocm_pkg::WAVE_PFC_A_TOP) ||
                                    (wave_mode == ocm_pkg::WAVE_PC_A_TOP));
          if (connected && match) begin
            state_next = ~state_now;
          end
        end else if (out_mode[1]) begin
          connected = 1'b1;
          // RULE11: clear up, set down
          // RULE12: set up, clear down
          if (match) begin
            state_next = (out_mode == ocm_pkg::OUT_SET) ^ count_down;
          end
        end
      end
      default: begin
        // reserved mode: leave the pin to the port and hold state
        connected  = 1'b0;
        state_next = state_now;
      end
    endcase
  end

endmodule

`default_nettype wire

/* File: rtl/timer_output_ctrl.sv */
// compare output control for two 16-bit timers, three channels each
// assumes a byte-wide data-space register port from the processor and
// counter event pulses already qualified by each timer's own tick
`timescale 1ns/1ns
`default_nettype none

// Operation
// RULE1: control a fields at 7:6, 5:4, 3:2, 1:0
// RULE2: nonzero mode field takes over the pin; here reserved mode 13 and blocked toggles leave it to the port
// RULE3: pin driven only when direction bit set
// RULE4: mode zero leaves the pin to port
// RULE5: non-pwm: toggle, clear, set on match
// RULE6: fast pwm toggle only channel a, mode 15
// RULE7: fast non-inverting: clear match, set bottom
// RULE8: fast inverting: set match, clear bottom
// RULE9: fast pwm ignores match when compare equals top
// RULE10: dual-slope toggle only channel a, mode 9/11
// RULE11: dual non-inverting: clear up, set down
// RULE12: dual inverting: set up, clear down
// RULE13: software uses i/o or data-space addresses
// RULE14: waveform mode joins control b and a bits
// RULE15: dual-slope direction reverses at top and bottom
// RULE16: actions land in the detecting cycle
module timer_output_ctrl (
  input  wire logic       clock,          // 25 MHz i/o clock
  input  wire logic       resetn,         // synchronous, active low
  input  wire logic [7:0] io_addr,        // data-space address
  input  wire logic [7:0] io_wdata,       // write data
  input  wire logic       io_write,       // write strobe
  input  wire logic       io_read,        // read strobe
  output logic      [7:0] io_rdata,       // read data, one cycle after strobe
  input  wire logic [2:0] t1_match,       // timer one matches, c b a
  input  wire logic [2:0] t1_cmp_at_top,  // timer one compare values equal top
  input  wire logic       t1_at_top,      // timer one counter at top
  input  wire logic       t1_at_bottom,   // timer one counter at bottom
  input  wire logic [2:0] t3_match,       // timer three matches, c b a
  input  wire logic [2:0] t3_cmp_at_top,  // timer three compare values equal top
  input  wire logic       t3_at_top,      // timer three counter at top
  input  wire logic       t3_at_bottom,   // timer three counter at bottom
  input  wire logic [5:0] port_data,      // ordinary port values, t3 c b a, t1 c b a
  input  wire logic [5:0] port_ddr,       // data direction bits, same order
  output logic      [5:0] pin_out,        // pin output level
  output logic      [5:0] pin_oe,         // pin driver enable
  output logic      [5:0] compare_output  // compare output state
);

  // ***************************************************************
  // register file state
  // ***************************************************************
  logic [7:0] ctrl_a_reg [2];   // output control a per timer
  logic [7:0] ctrl_a_next [2];
  logic [7:0] ctrl_b_reg [2];   // control b per timer, waveform high bits used
  logic [7:0] ctrl_b_next [2];
  logic [7:0] rdata_reg;        // registered read answer
  logic [7:0] rdata_next;

  // ***************************************************************
  // output and direction state
  // ***************************************************************
  logic [1:0] down_reg;         // dual-slope direction per timer
  logic [1:0] down_next;
  logic [5:0] oc_reg;           // compare output state per channel
  logic [5:0] oc_next;
  logic [5:0] pin_out_reg;
  logic [5:0] pin_out_next;
  logic [5:0] pin_oe_reg;
  logic [5:0] pin_oe_next;
  logic [5:0] conn;             // channel owns its pin
  logic [5:0] ch_match;         // matches gathered per channel
  logic [5:0] ch_at_top;        // compare-equals-top per channel
  logic [1:0] at_top;           // counter at top per timer
  logic [1:0] at_bottom;        // counter at bottom per timer

  assign ch_match  = {t3_match, t1_match};
  assign ch_at_top = {t3_cmp_at_top, t1_cmp_at_top};
  assign at_top    = {t3_at_top, t1_at_top};
  assign at_bottom = {t3_at_bottom, t1_at_bottom};

  // ***************************************************************
  // helpers
  // ***************************************************************
  // RULE14: high bits from b, low from a
  function automatic logic [3:0] wave_of(input logic [7:0] ca, input logic [7:0] cb);
    wave_of = {cb[ocm_pkg::WAVE_HIGH_LSB +: 2], ca[ocm_pkg::WAVE_LOW_LSB +: 2]};
  endfunction

  // RULE1: channel field positions
  function automatic logic [1:0] mode_of(input logic [7:0] ca, input int chan);
    case (chan)
      0:       mode_of = ca[ocm_pkg::CHAN_A_LSB +: 2];
      1:       mode_of = ca[ocm_pkg::CHAN_B_LSB +: 2];
      default: mode_of = ca[ocm_pkg::CHAN_C_LSB +: 2];
    endcase
  endfunction

  // ***************************************************************
  // register port
  // ***************************************************************
  // timer one sits in i/o space, so its data-space address is offset;
  // timer three lives only in extended space and is reached directly
  always_comb begin
    ctrl_a_next = ctrl_a_reg;
    ctrl_b_next = ctrl_b_reg;
    rdata_next  = ocm_pkg::READ_IDLE;
    // RULE13: data-space decode
    if (io_addr == ocm_pkg::T1_CTRL_A_IO + ocm_pkg::IO_DATA_OFFSET) begin
      if (io_write) begin
        ctrl_a_next[0] = io_wdata;
      end
      if (io_read) begin
        rdata_next = ctrl_a_reg[0];
      end
    end else if (io_addr == ocm_pkg::T1_CTRL_B_IO + ocm_pkg::IO_DATA_OFFSET) begin
      if (io_write) begin
        ctrl_b_next[0] = io_wdata & ocm_pkg::CTRL_B_WMASK;
      end
      if (io_read) begin
        rdata_next = ctrl_b_reg[0];
      end
    end else if (io_addr == ocm_pkg::T3_CTRL_A_EXT) begin
      if (io_write) begin
        ctrl_a_next[1] = io_wdata;
      end
      if (io_read) begin
        rdata_next = ctrl_a_reg[1];
      end
    end else if (io_addr == ocm_pkg::T3_CTRL_B_EXT) begin
      if (io_write) begin
        ctrl_b_next[1] = io_wdata & ocm_pkg::CTRL_B_WMASK;
      end
      if (io_read) begin
        rdata_next = ctrl_b_reg[1];
      end
    end else begin
      // unmapped: writes dropped, reads give zero
      rdata_next = ocm_pkg::READ_IDLE;
    end
  end

  // register file flops
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctrl_a_reg <= '{ocm_pkg::CTRL_RESET, ocm_pkg::CTRL_RESET};
      ctrl_b_reg <= '{ocm_pkg::CTRL_RESET, ocm_pkg::CTRL_RESET};
      rdata_reg  <= ocm_pkg::READ_IDLE;
    end else begin
      ctrl_a_reg <= ctrl_a_next;
      ctrl_b_reg <= ctrl_b_next;
      rdata_reg  <= rdata_next;
    end
  end

  // ***************************************************************
  // counting direction
  // ***************************************************************
  // tracked here from the end-point pulses; a reset counter starts
  // at bottom counting up
  always_comb begin
    down_next = down_reg;
    for (int t = 0; t < 2; t++) begin
      // RULE15: reverse at each end
      if (at_top[t]) begin
        down_next[t] = 1'b1;
      end else if (at_bottom[t]) begin
        down_next[t] = 1'b0;
      end
    end
  end

  // ***************************************************************
  // channel units
  // ***************************************************************
  // six independent channels; direction used is the one before this
  // cycle's end-point event
  for (genvar k = 0; k < 6; k++) begin : g_chan
    channel_output_unit #(
      .IS_CHAN_A  ((k % 3) == 0)
    ) u_chan (
      .out_mode   (mode_of(ctrl_a_reg[k / 3], k % 3)),
      .wave_mode  (wave_of(ctrl_a_reg[k / 3], ctrl_b_reg[k / 3])),
      .match      (ch_match[k]),
      .bottom     (at_bottom[k / 3]),
      .count_down (down_reg[k / 3]),
      .cmp_at_top (ch_at_top[k]),
      .state_now  (oc_reg[k]),
      .connected  (conn[k]),
      .state_next (oc_next[k])
    );
  end

  // ***************************************************************
  // pin mux
  // ***************************************************************
  // pins are computed from next state so they change on the same
  // edge as the compare output itself
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      // RULE2: compare output takes the pin
      // RULE16: same-cycle action
      pin_out_next[k] = conn[k] ? oc_next[k] : port_data[k];
      // RULE3: driver follows direction bit
      pin_oe_next[k]  = port_ddr[k];
    end
  end

  // output and direction flops
  always_ff @(posedge clock) begin
    if (!resetn) begin
      down_reg    <= 2'h0;
      oc_reg      <= 6'h00;
      pin_out_reg <= 6'h00;
      pin_oe_reg  <= 6'h00;
    end else begin
      down_reg    <= down_next;
      oc_reg      <= oc_next;
      pin_out_reg <= pin_out_next;
      pin_oe_reg  <= pin_oe_next;
    end
  end

  assign io_rdata       = rdata_reg;
  assign pin_out        = pin_out_reg;
  assign pin_oe         = pin_oe_reg;
  assign compare_output = oc_reg;

endmodule

`default_nettype wire

/* File: tb/timer_output_ctrl_props.sv */
// assertions on the ports of the compare output control
// assumes one clock and a copy of timer one control kept here
`timescale 1ns/1ns
`default_nettype none
module timer_output_ctrl_props (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic [7:0] io_addr,
  input  wire logic [7:0] io_wdata,
  input  wire logic       io_write,
  input  wire logic       io_read,
  input  wire logic [7:0] io_rdata,
  input  wire logic [2:0] t1_match,
  input  wire logic [2:0] t1_cmp_at_top,
  input  wire logic       t1_at_bottom,
  input  wire logic [5:0] port_data,
  input  wire logic [5:0] port_ddr,
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] compare_output
);
  logic [7:0] ca_reg, ca_next;  // copy of timer one control a
  logic [1:0] wh_reg, wh_next;  // copy of its high waveform bits
  logic [3:0] wave;             // joined waveform mode
  // ****************************************
  // shadow of timer one control
  // ****************************************
  always_comb begin
    ca_next = ca_reg;
    wh_next = wh_reg;
    // only mapped writes move the copy
    if (io_write && io_addr == 8'h4f) ca_next = io_wdata;
    if (io_write && io_addr == 8'h4e) wh_next = io_wdata[4:3];
  end
  always_ff @(posedge clock) begin
    ca_reg <= resetn ? ca_next : 8'h00;
    wh_reg <= resetn ? wh_next : 2'h0;
  end
  assign wave = {wh_reg, ca_reg[1:0]};
  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  a_oe_follows_ddr: assert property ($past(resetn) |-> pin_oe == $past(port_ddr))
    else $error("pin enable does not follow direction");
  a_pin_source: assert property ($past(resetn) |->
    ((pin_out ^ compare_output) & (pin_out ^ $past(port_data))) == 6'h00)
    else $error("pin level from neither source");
  a_rdata_idle: assert property ($past(resetn) && !$past(io_read) |-> io_rdata == 8'h00)
    else $error("read data without a read");
  a_read_back: assert property (io_read && io_addr == 8'h4f |=> io_rdata == $past(ca_reg))
    else $error("control a read wrong");
  a_mode_zero: assert property (ca_reg[7:6] == 2'h0 |=> pin_out[0] == $past(port_data[0]))
    else $error("idle channel not port driven");
  a_plain_toggle: assert property (wave == 4'h0 && ca_reg[7:6] == 2'h1 && t1_match[0]
    |=> compare_output[0] != $past(compare_output[0]))
    else $error("no toggle on match");
  a_plain_clear: assert property (wave == 4'h0 && ca_reg[5:4] == 2'h2 && t1_match[1] |=> !compare_output[1])
    else $error("no clear on match");
  a_fast_bottom: assert property (wave == 4'he && ca_reg[7:6] == 2'h2 && t1_at_bottom |=> compare_output[0])
    else $error("no set at bottom");
  a_fast_top_skip: assert property (wave == 4'he && ca_reg[7] && t1_match[0] && t1_cmp_at_top[0]
    && !t1_at_bottom |=> $stable(compare_output[0]))
    else $error("match at top not ignored");
  a_reserved_hold: assert property (wave == 4'hd && t1_match[0] |=> $stable(compare_output[0]))
    else $error("reserved mode moved output");
endmodule
bind timer_output_ctrl timer_output_ctrl_props chk (.clock(clock), .resetn(resetn), .io_addr(io_addr),
  .io_wdata(io_wdata), .io_write(io_write), .io_read(io_read), .io_rdata(io_rdata), .t1_match(t1_match),
  .t1_cmp_at_top(t1_cmp_at_top), .t1_at_bottom(t1_at_bottom), .port_data(port_data), .port_ddr(port_ddr),
  .pin_out(pin_out), .pin_oe(pin_oe), .compare_output(compare_output));
`default_nettype wire

/* File: tb/pad_load_model.sv */
// external loads on the six compare pins
// assumes a pull-up on every pin, so a released pin reads high
`timescale 1ns/1ns
`default_nettype none
module pad_load_model (
  input  wire logic [5:0] pin_out,   // level from the device
  input  wire logic [5:0] pin_oe,    // device driver enables
  output logic      [5:0] pad_level  // level the loads see
);
  // ****************************************
  // pad resolution
  // ****************************************
  // undriven pins float to the pull-up
  assign pad_level = (pin_out & pin_oe) | ~pin_oe;
endmodule
`default_nettype wire

/* File: tb/timer_output_ctrl_bench.sv */
// self-checking bench for the compare output control
// assumes the design top, the pad model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module timer_output_ctrl_bench;
  logic       clock, resetn, io_write, io_read;   // clock, reset, strobes
  logic [7:0] io_addr, io_wdata, io_rdata;        // register port
  logic [2:0] t1_match, t1_cmp_at_top, t3_match, t3_cmp_at_top;
  logic       t1_at_top, t1_at_bottom, t3_at_top, t3_at_bottom;
  logic [5:0] port_data, port_ddr, pin_out, pin_oe, compare_output, pad_level;
  int         n_mismatch, num_checks;            // counters
  int         cycles = 0;                        // clock cycles since start
  logic [3:0] waves [10] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hd, 4'he};  // toggle not allowed
  timer_output_ctrl uut (.clock(clock), .resetn(resetn), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_write(io_write), .io_read(io_read), .io_rdata(io_rdata), .t1_match(t1_match),
    .t1_cmp_at_top(t1_cmp_at_top), .t1_at_top(t1_at_top), .t1_at_bottom(t1_at_bottom),
    .t3_match(t3_match), .t3_cmp_at_top(t3_cmp_at_top), .t3_at_top(t3_at_top),
    .t3_at_bottom(t3_at_bottom), .port_data(port_data), .port_ddr(port_ddr), .pin_out(pin_out),
    .pin_oe(pin_oe), .compare_output(compare_output));
  pad_load_model loads (.pin_out(pin_out), .pin_oe(pin_oe), .pad_level(pad_level));
  // ****************************************
  // clock and hang guard
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // the run needs about 130 cycles; far beyond means a hang
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      final_report();
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // one write strobe, driven between rising edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    {io_addr, io_wdata, io_write} = {a, d, 1'b1};
    @(negedge clock);
    io_write = 1'b0;
  endtask
  // read data stands in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(negedge clock);
    {io_addr, io_read} = {a, 1'b1};
    @(negedge clock);
    io_read = 1'b0;
    chk(n, e, io_rdata);
  endtask
  // one cycle of counter events on one timer
  task automatic ev(input bit t3, input logic [2:0] m, input logic [2:0] ct, input logic tp, input logic bt);
    @(negedge clock);
    if (t3) {t3_match, t3_cmp_at_top, t3_at_top, t3_at_bottom} = {m, ct, tp, bt};
    else {t1_match, t1_cmp_at_top, t1_at_top, t1_at_bottom} = {m, ct, tp, bt};
    @(negedge clock);
    {t1_match, t1_cmp_at_top, t1_at_top, t1_at_bottom, t3_match, t3_cmp_at_top, t3_at_top, t3_at_bottom} = '0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {io_addr, io_wdata, io_write, io_read, n_mismatch, num_checks} = '0;
    {t1_match, t1_cmp_at_top, t1_at_top, t1_at_bottom, t3_match, t3_cmp_at_top, t3_at_top, t3_at_bottom} = '0;
    {port_data, port_ddr, resetn} = {6'h00, 6'h3f, 1'b0};
    repeat (3) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    rd(8'h4f, 8'h00, "t1 ctrl a reset");
    rd(8'h8b, 8'h00, "t3 ctrl a reset");
    wr(8'h50, 8'hff);
    rd(8'h50, 8'h00, "unmapped");
    wr(8'h8a, 8'hff);
    rd(8'h8a, 8'hdf, "t3 ctrl b");
    wr(8'h8a, 8'h00);
    wr(8'h4f, 8'h6c);
    rd(8'h4f, 8'h6c, "t1 ctrl a");
    $display("test done: registers");
    ev(0, 3'b111, 3'b000, 1'b0, 1'b0);
    chk("t1 out", 8'h05, {5'h0, compare_output[2:0]});
    chk("t1 pin", 8'h05, {5'h0, pin_out[2:0]});
    ev(0, 3'b111, 3'b000, 1'b0, 1'b0);
    chk("t1 out again", 8'h04, {5'h0, compare_output[2:0]});
    port_data = 6'h28;
    ev(1, 3'b111, 3'b000, 1'b0, 1'b0);
    chk("t3 pin", 8'h05, {5'h0, pin_out[5:3]});
    chk("t3 out", 8'h00, {5'h0, compare_output[5:3]});
    port_ddr = 6'h01;
    @(negedge clock);
    chk("pin enable", 8'h01, {2'h0, pin_oe});
    chk("pad", 8'h3e, {2'h0, pad_level});
    port_ddr = 6'h3f;
    $display("test done: non-pwm");
    wr(8'h4e, 8'h18);
    wr(8'h4f, 8'hb6);
    ev(0, 3'b111, 3'b000, 1'b0, 1'b0);
    chk("fast match", 8'h06, {5'h0, compare_output[2:0]});
    ev(0, 3'b000, 3'b000, 1'b0, 1'b1);
    chk("fast bottom", 8'h05, {5'h0, compare_output[2:0]});
    ev(0, 3'b111, 3'b011, 1'b0, 1'b0);
    chk("fast at top", 8'h05, {5'h0, compare_output[2:0]});
    chk("fast pin", 8'h01, {5'h0, pin_out[2:0]});
    wr(8'h4f, 8'h43);
    ev(0, 3'b001, 3'b000, 1'b0, 1'b0);
    chk("mode 15 toggle", 8'h04, {5'h0, compare_output[2:0]});
    port_data = 6'h29;
    foreach (waves[i]) begin
      wr(8'h4e, {3'h0, waves[i][3:2], 3'h0});
      wr(8'h4f, {6'h10, waves[i][1:0]});
      ev(0, 3'b001, 3'b000, 1'b0, 1'b0);
      chk("toggle blocked", 8'h01, {6'h0, compare_output[0], pin_out[0]});
    end
    // dual-slope mode 11 lets channel a toggle
    wr(8'h4e, 8'h10);
    wr(8'h4f, 8'h43);
    ev(0, 3'b001, 3'b000, 1'b0, 1'b0);
    chk("mode 11 toggle", 8'h05, {5'h0, compare_output[2:0]});
    // clear-on-match mode 12 toggles like normal mode
    wr(8'h4e, 8'h18);
    wr(8'h4f, 8'h40);
    ev(0, 3'b001, 3'b000, 1'b0, 1'b0);
    chk("mode 12 toggle", 8'h04, {5'h0, compare_output[2:0]});
    $display("test done: fast pwm");
    wr(8'h8a, 8'h10);
    wr(8'h8b, 8'h6d);
    ev(1, 3'b111, 3'b000, 1'b0, 1'b0);
    chk("dual up", 8'h05, {5'h0, compare_output[5:3]});
    ev(1, 3'b000, 3'b000, 1'b1, 1'b0);
    ev(1, 3'b111, 3'b000, 1'b0, 1'b0);
    chk("dual down", 8'h02, {5'h0, compare_output[5:3]});
    chk("dual pin", 8'h02, {5'h0, pin_out[5:3]});
    ev(1, 3'b000, 3'b000, 1'b0, 1'b1);
    ev(1, 3'b111, 3'b000, 1'b0, 1'b0);
    chk("dual up again", 8'h05, {5'h0, compare_output[5:3]});
    $display("test done: dual slope");
    final_report();
  end
endmodule
`default_nettype wire
